// ### hdl/ssrac_regs.vh
// Register offsets, fields and timing counts of the ramp converter sequencer
`ifndef SSRAC_REGS_VH
`define SSRAC_REGS_VH

// ==========================================================
// Register offsets (byte addresses)
`define SSRAC_CTRL_ADDR 8'h00
`define SSRAC_STATUS_ADDR 8'h04
`define SSRAC_IRQ_STAT_ADDR 8'h08
`define SSRAC_IRQ_CLR_ADDR 8'h0C
`define SSRAC_IRQ_EN_ADDR 8'h10
`define SSRAC_RAW_ADDR 8'h14
`define SSRAC_ZERO_ADDR 8'h18
`define SSRAC_FULL_ADDR 8'h1C
`define SSRAC_RESULT_ADDR 8'h20
`define SSRAC_ACQ_ADDR 8'h24
`define SSRAC_TMO_ADDR 8'h28

// ==========================================================
// Control fields
`define SSRAC_CTRL_START_BIT 0
`define SSRAC_CTRL_CHAN_LSB 4
`define SSRAC_CTRL_CHAN_MSB 6

// Status fields
`define SSRAC_STAT_BUSY_BIT 0
`define SSRAC_STAT_VALID_BIT 1
`define SSRAC_STAT_RAMP_BIT 2

// Interrupt fields
`define SSRAC_IRQ_DONE_BIT 0
`define SSRAC_IRQ_TMO_BIT 1
`define SSRAC_IRQ_CALERR_BIT 2

// ==========================================================
// Channel codes
`define SSRAC_CHAN_GROUND 3'h0
`define SSRAC_CHAN_REF 3'h7

// Timing: clock 5 ns; acquisition 40 us; mux address time 1 us
`define SSRAC_CLK_PS 5000
`define SSRAC_ACQ_NS 40000
`define SSRAC_MUX_NS 1000
`define SSRAC_ACQ_CYC ((`SSRAC_ACQ_NS * 1000 + `SSRAC_CLK_PS - 1) / `SSRAC_CLK_PS)
`define SSRAC_MUX_CYC ((`SSRAC_MUX_NS * 1000 + `SSRAC_CLK_PS - 1) / `SSRAC_CLK_PS)
// Ramp timeout: 350 us conversion limit, doubled for margin
`define SSRAC_TMO_NS 700000
`define SSRAC_TMO_CYC (`SSRAC_TMO_NS / (`SSRAC_CLK_PS / 1000))

// Reset values
`define SSRAC_IRQ_EN_RST 3'h0

`endif

// ### hdl/ssrac_sync3.v
// Three-stage input synchroniser with agreement filter
module ssrac_sync3 (
    input wire clk,
    input wire reset,
    input wire ce,
    input wire async_in,
    output reg sync_out
);
    reg s1_q;
    reg s2_q;
    reg s3_q;

    // ==========================================================
    // Chain; output updates once stages two and three agree
    always @(posedge clk)
    begin
        if (reset)
        begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            sync_out <= 1'b1;
        end
        else if (ce)
        begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                sync_out <= s3_q;
        end
    end
endmodule // ssrac_sync3

// ### hdl/ssrac_seq.v
// Host sequencer for a single-slope ramp converter
`include "ssrac_regs.vh"

module ssrac_seq #(
    parameter CNT_W = 20,
    parameter ACQ_CYCLES = `SSRAC_ACQ_CYC,
    parameter TMO_CYCLES = `SSRAC_TMO_CYC
) (
    input wire clk,
    input wire reset,
    input wire ce,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    output wire irq,
    output reg chan_sel_bit0,
    output reg chan_sel_bit1,
    output reg chan_sel_bit2,
    output reg ramp_start,
    input wire ramp_stop
);

    // ==========================================================
    // States
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_ACQ = 5'h02;
    localparam [4:0] ST_RAMP = 5'h04;
    localparam [4:0] ST_DIV = 5'h08;
    localparam [4:0] ST_DONE = 5'h10;

    reg [4:0] state_q;
    reg [2:0] chan_q;
    reg [CNT_W-1:0] cnt_q;
    reg [CNT_W-1:0] raw_q;
    reg [CNT_W-1:0] zero_q;
    reg [CNT_W-1:0] full_q;
    reg [8:0] result_q;
    reg valid_q;
    reg [2:0] irq_stat_q;
    reg [2:0] irq_en_q;
    reg [CNT_W+8:0] num_q;
    reg [CNT_W:0] den_q;
    reg [CNT_W+8:0] quo_q;
    reg [5:0] div_cnt_q;
    reg stop_prev_q;
    wire stop_s;
    reg [2:0] ev_set;

    // ==========================================================
    // Ramp stop from the pin, three-stage filtered
    ssrac_sync3 u_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .async_in(ramp_stop),
        .sync_out(stop_s)
    );

    wire stop_fall = stop_prev_q & ~stop_s;
    wire start_req = wr && (addr == `SSRAC_CTRL_ADDR) &&
        wdata[`SSRAC_CTRL_START_BIT];
    wire [CNT_W:0] span = {1'b0, full_q} - {1'b0, zero_q};
    wire [CNT_W:0] diff = {1'b0, raw_q} - {1'b0, zero_q};
    // Division step: shifted remainder and trial subtract
    wire [CNT_W:0] rem_sh = {cnt_q, num_q[CNT_W+8]};
    wire [CNT_W:0] rem_sub = rem_sh - den_q;
    wire rem_ge = (rem_sh >= den_q);

    // Interrupt level output
    assign irq = |(irq_stat_q & irq_en_q);

    // ==========================================================
    // Sequencer
    always @(posedge clk)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
            chan_q <= 3'h0;
            cnt_q <= {CNT_W{1'b0}};
            raw_q <= {CNT_W{1'b0}};
            zero_q <= {CNT_W{1'b0}};
            full_q <= {CNT_W{1'b1}};
            result_q <= 9'h000;
            valid_q <= 1'b0;
            num_q <= {(CNT_W+9){1'b0}};
            den_q <= {(CNT_W+1){1'b0}};
            quo_q <= {(CNT_W+9){1'b0}};
            div_cnt_q <= 6'h00;
            ramp_start <= 1'b0;
            chan_sel_bit0 <= 1'b0;
            chan_sel_bit1 <= 1'b0;
            chan_sel_bit2 <= 1'b0;
            stop_prev_q <= 1'b1;
            ev_set <= 3'h0;
        end
        else if (ce)
        begin
            stop_prev_q <= stop_s;
            ev_set <= 3'h0;
            case (state_q)
                ST_IDLE:
                begin
                    if (start_req)
                    begin
                        // Address the mux while ramp start is low
                        chan_q <= wdata[`SSRAC_CTRL_CHAN_MSB:
                            `SSRAC_CTRL_CHAN_LSB];
                        chan_sel_bit0 <= wdata[`SSRAC_CTRL_CHAN_LSB];
                        chan_sel_bit1 <= wdata[`SSRAC_CTRL_CHAN_LSB+1];
                        chan_sel_bit2 <= wdata[`SSRAC_CTRL_CHAN_MSB];
                        cnt_q <= {CNT_W{1'b0}};
                        state_q <= ST_ACQ;
                    end
                end
                ST_ACQ:
                begin
                    // Hold low for acquisition plus mux settling
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q >= ACQ_CYCLES + `SSRAC_MUX_CYC - 1)
                    begin
                        ramp_start <= 1'b1;
                        cnt_q <= {CNT_W{1'b0}};
                        state_q <= ST_RAMP;
                    end
                end
                ST_RAMP:
                begin
                    cnt_q <= cnt_q + 1'b1;
                    if (stop_fall)
                    begin
                        // Ramp time captured
                        ramp_start <= 1'b0;
                        raw_q <= cnt_q;
                        if (chan_q == `SSRAC_CHAN_GROUND)
                            zero_q <= cnt_q;
                        if (chan_q == `SSRAC_CHAN_REF)
                            full_q <= cnt_q;
                        state_q <= ST_DIV;
                    end
                    else if (cnt_q >= TMO_CYCLES - 1)
                    begin
                        ramp_start <= 1'b0;
                        ev_set[`SSRAC_IRQ_TMO_BIT] <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_DIV:
                begin
                    // Set up (diff*256 + span/2) / span
                    if (span == {(CNT_W+1){1'b0}} || span[CNT_W])
                    begin
                        ev_set[`SSRAC_IRQ_CALERR_BIT] <= 1'b1;
                        result_q <= 9'h000;
                        ev_set[`SSRAC_IRQ_DONE_BIT] <= 1'b1;
                        valid_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        num_q <= (diff[CNT_W] ? {(CNT_W+9){1'b0}} :
                            {1'b0, diff[CNT_W-1:0], 8'h00}) +
                            {9'h000, span[CNT_W:1]};
                        den_q <= span;
                        quo_q <= {(CNT_W+9){1'b0}};
                        div_cnt_q <= 6'h00;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE:
                begin
                    // Restoring division, one bit per cycle
                    if (div_cnt_q == CNT_W + 9)
                    begin
                        result_q <= (quo_q > 9'h100) ? 9'h100 :
                            quo_q[8:0];
                        valid_q <= 1'b1;
                        ev_set[`SSRAC_IRQ_DONE_BIT] <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        div_cnt_q <= div_cnt_q + 1'b1;
                        num_q <= {num_q[CNT_W+7:0], 1'b0};
                        quo_q <= {quo_q[CNT_W+7:0], rem_ge};
                        cnt_q <= rem_ge ? rem_sub[CNT_W-1:0] :
                            rem_sh[CNT_W-1:0];
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
            if (state_q == ST_DIV)
                cnt_q <= {CNT_W{1'b0}};
        end
    end

    // ==========================================================
    // Interrupt registers; set wins over clear
    always @(posedge clk)
    begin
        if (reset)
        begin
            irq_stat_q <= 3'h0;
            irq_en_q <= `SSRAC_IRQ_EN_RST;
        end
        else if (ce)
        begin
            if (wr && addr == `SSRAC_IRQ_EN_ADDR)
                irq_en_q <= wdata[2:0];
            irq_stat_q <= (irq_stat_q &
                ~((wr && addr == `SSRAC_IRQ_CLR_ADDR) ? wdata[2:0] : 3'h0))
                | ev_set;
        end
    end

    // ==========================================================
    // Read port, data one cycle after strobe
    always @(posedge clk)
    begin
        if (reset)
            rdata <= 32'h00000000;
        else if (ce)
        begin
            rdata <= 32'h00000000;
            if (rd)
            begin
                if (addr == `SSRAC_CTRL_ADDR)
                    rdata <= {25'h0, chan_q, 4'h0};
                else if (addr == `SSRAC_STATUS_ADDR)
                    rdata <= {29'h0, ramp_start, valid_q, ~state_q[0]};
                else if (addr == `SSRAC_IRQ_STAT_ADDR)
                    rdata <= {29'h0, irq_stat_q};
                else if (addr == `SSRAC_IRQ_EN_ADDR)
                    rdata <= {29'h0, irq_en_q};
                else if (addr == `SSRAC_RAW_ADDR)
                    rdata <= {{(32-CNT_W){1'b0}}, raw_q};
                else if (addr == `SSRAC_ZERO_ADDR)
                    rdata <= {{(32-CNT_W){1'b0}}, zero_q};
                else if (addr == `SSRAC_FULL_ADDR)
                    rdata <= {{(32-CNT_W){1'b0}}, full_q};
                else if (addr == `SSRAC_RESULT_ADDR)
                    rdata <= {23'h0, result_q};
            end
        end
    end
endmodule // ssrac_seq

// ### dv/ssrac_seq_sva.sv
// Checker of the sequencer pins and register port
`include "ssrac_regs.vh"
module ssrac_seq_sva #(
    parameter ACQ_CYCLES = 20,
    parameter TMO_CYCLES = 500
) (
    input wire clk,
    input wire reset,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata,
    input wire irq,
    input wire chan_sel_bit0,
    input wire chan_sel_bit1,
    input wire chan_sel_bit2,
    input wire ramp_start,
    input wire ramp_stop
);
    localparam int ACQ_LO = ACQ_CYCLES + 198;
    localparam int ACQ_HI = ACQ_CYCLES + 202;
    localparam int TMO_LIM = TMO_CYCLES - 4;
    wire [2:0] chan = {chan_sel_bit2, chan_sel_bit1, chan_sel_bit0};
    wire start_wr = wr && addr == `SSRAC_CTRL_ADDR && wdata[0];
    wire res_rd = rd && addr == `SSRAC_RESULT_ADDR;
    reg [2:0] chan_q;
    reg [19:0] quiet_q;
    reg [19:0] hi_q;
    reg [19:0] end_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================================
    // Cycle counters: settle time, ramp length, time since ramp end
    always @(posedge clk)
    begin
        chan_q <= chan;
        if (reset || ramp_start || chan != chan_q)
            quiet_q <= 20'h0;
        else if (quiet_q != 20'hFFFFF)
            quiet_q <= quiet_q + 20'h1;
        hi_q <= (reset || !ramp_start) ? 20'h0 : hi_q + 20'h1;
        if (reset || ramp_start)
            end_q <= 20'h0;
        else if (end_q != 20'hFFFFF)
            end_q <= end_q + 20'h1;
    end
    chan_stable_a: assert property (
        ramp_start && $past(ramp_start) |-> $stable(chan))
        else $error("channel code moved during ramp");
    acq_hold_a: assert property (
        $rose(ramp_start) |-> quiet_q >= ACQ_CYCLES + 190)
        else $error("ramp began before acquisition ended");
    start_delay_a: assert property (
        start_wr |-> ##[ACQ_LO:ACQ_HI] $rose(ramp_start))
        else $error("ramp start late after start write");
    ramp_end_a: assert property (
        ramp_start && $fell(ramp_stop) |-> ##[1:6] !ramp_start)
        else $error("ramp not ended after stop fell");
    ramp_keep_a: assert property (
        (ramp_start && ramp_stop)[*4] ##0 hi_q < TMO_LIM |=> ramp_start)
        else $error("ramp ended while stop high");
    ramp_tmo_a: assert property (
        ramp_start |-> hi_q <= TMO_CYCLES + 2)
        else $error("ramp outlived its limit");
    irq_cause_a: assert property (
        $rose(irq) |-> $past(wr) || end_q <= 64)
        else $error("interrupt rose without cause");
    result_range_a: assert property (
        $past(res_rd) |-> rdata <= 32'h100)
        else $error("result above full scale");
    cover property ($fell(ramp_start) && ramp_stop == 1'b0);
    cover property (hi_q == TMO_CYCLES);
    cover property ($rose(irq));
endmodule // ssrac_seq_sva
bind ssrac_seq ssrac_seq_sva #(
    .ACQ_CYCLES(ACQ_CYCLES),
    .TMO_CYCLES(TMO_CYCLES)
) chk_u (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .irq(irq), .chan_sel_bit0(chan_sel_bit0),
    .chan_sel_bit1(chan_sel_bit1), .chan_sel_bit2(chan_sel_bit2),
    .ramp_start(ramp_start), .ramp_stop(ramp_stop));

// ### dv/ssrac_dev_model.sv
// Behavioural converter: channel decode, ramp and comparator
module ssrac_dev_model (
    input wire clk,
    input wire chan_sel_bit0,
    input wire chan_sel_bit1,
    input wire chan_sel_bit2,
    input wire ramp_start,
    input wire stuck,
    output logic ramp_stop,
    output logic [2:0] seen_chan
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] chan;
    logic prev = 1'b0;
    int left = 0;
    // ==========================================================
    // Ramp length in cycles stands for the selected voltage
    function automatic int ramp_len(input logic [2:0] c);
        if (c == 3'h0)
            return 10;
        if (c == 3'h7)
            return 394;
        return 10 + 50 * c;
    endfunction
    assign chan = {chan_sel_bit2, chan_sel_bit1, chan_sel_bit0};
    // Track while low, discharge while high
    always @(posedge clk)
    begin
        prev <= ramp_start;
        if (!ramp_start)
            left <= ramp_len(chan);
        else if (left > 0)
            left <= left - 1;
        if (ramp_start && !prev)
            seen_chan <= chan;
    end
    // Open collector comparator, pulled high when released
    assign ramp_stop = !ramp_start || left > 0 || stuck;
endmodule // ssrac_dev_model

// ### dv/ssrac_seq_tb_top.sv
// Register-level bench of the ramp converter sequencer
`include "ssrac_regs.vh"
module ssrac_seq_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1, ce = 1, wr = 0, rd = 0, stuck = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic irq, chan_sel_bit0, chan_sel_bit1, chan_sel_bit2;
    logic ramp_start, ramp_stop;
    logic [2:0] seen_chan;
    int num_errors = 0, comparisons = 0, cycles = 0, raw_z, k;
    always #2.5 clk = ~clk;
    ssrac_seq #(.ACQ_CYCLES(20), .TMO_CYCLES(500)) dut_u (.clk(clk),
        .reset(reset), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq), .chan_sel_bit0(chan_sel_bit0),
        .chan_sel_bit1(chan_sel_bit1), .chan_sel_bit2(chan_sel_bit2),
        .ramp_start(ramp_start), .ramp_stop(ramp_stop));
    ssrac_dev_model dev_u (.clk(clk), .chan_sel_bit0(chan_sel_bit0),
        .chan_sel_bit1(chan_sel_bit1), .chan_sel_bit2(chan_sel_bit2),
        .ramp_start(ramp_start), .stuck(stuck), .ramp_stop(ramp_stop),
        .seen_chan(seen_chan));
    // ==========================================================
    // Compare, bus access and one whole conversion
    task automatic chk(input string name, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, m,
        input string name);
        rd_reg(a);
        chk(name, e, rv & m);
    endtask
    task automatic conv(input logic [2:0] ch);
        int n = 0;
        wr_reg(`SSRAC_IRQ_CLR_ADDR, 32'h7);
        wr_reg(`SSRAC_CTRL_ADDR, {25'h0, ch, 4'h1});
        do
        begin
            rd_reg(`SSRAC_IRQ_STAT_ADDR);
            n++;
        end
        while (rv[1:0] === 2'h0 && n < 1000);
        if (n >= 1000)
        begin
            num_errors++;
            $display("FAIL conversion exp done got none");
            end_sim;
        end
        chk("channel seen", {29'h0, ch}, {29'h0, seen_chan});
    endtask
    task automatic end_sim;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            num_errors++;
            end_sim;
        end
    end
    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        chk("idle pins", 32'h0, {28'h0, ramp_start, chan_sel_bit2,
            chan_sel_bit1, chan_sel_bit0});
        // Write with clock enable low must be lost
        ce <= 1'b0;
        wr_reg(`SSRAC_IRQ_EN_ADDR, 32'h7);
        ce <= 1'b1;
        rd_chk(`SSRAC_IRQ_EN_ADDR, 32'h0, 32'h7, "irq_en reset");
        rd_chk(8'h3C, 32'h0, 32'hFFFFFFFF, "unmapped");
        wr_reg(`SSRAC_IRQ_EN_ADDR, 32'h3);
        conv(3'h0);
        rd_reg(`SSRAC_RAW_ADDR);
        raw_z = rv;
        conv(3'h7);
        rd_chk(`SSRAC_RAW_ADDR, raw_z + 384, 32'hFFFFF, "span");
        rd_chk(`SSRAC_ZERO_ADDR, raw_z, 32'hFFFFF, "zero cal");
        rd_chk(`SSRAC_FULL_ADDR, raw_z + 384, 32'hFFFFF, "full cal");
        rd_chk(`SSRAC_STATUS_ADDR, 32'h2, 32'h7, "status idle");
        rd_chk(`SSRAC_CTRL_ADDR, 32'h70, 32'hFF, "chan readback");
        for (k = 1; k < 7; k++)
        begin
            conv(k[2:0]);
            rd_chk(`SSRAC_RESULT_ADDR, (k * 25600 + 384) / 768, 32'h1FF,
                "result");
            chk("irq set", 32'h1, {31'h0, irq});
            wr_reg(`SSRAC_IRQ_CLR_ADDR, 32'h7);
            #1;
            chk("irq clear", 32'h0, {31'h0, irq});
        end
        wr_reg(`SSRAC_IRQ_EN_ADDR, 32'h0);
        conv(3'h5);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd_chk(`SSRAC_IRQ_STAT_ADDR, 32'h1, 32'h1, "done sticky");
        wr_reg(`SSRAC_IRQ_CLR_ADDR, 32'h7);
        rd_chk(`SSRAC_IRQ_STAT_ADDR, 32'h0, 32'h7, "stat clear");
        stuck <= 1'b1;
        wr_reg(`SSRAC_IRQ_EN_ADDR, 32'h2);
        conv(3'h2);
        rd_chk(`SSRAC_IRQ_STAT_ADDR, 32'h2, 32'h2, "timeout");
        chk("irq timeout", 32'h1, {31'h0, irq});
        chk("ramp dropped", 32'h0, {31'h0, ramp_start});
        end_sim;
    end
endmodule // ssrac_seq_tb_top
